// *** dv/sensor_status_model.sv ***
// Far-side model: power-on status, filter state and raw remote low byte
module sensor_status_model #(
	parameter int READY_DELAY = 20       // Cycles of not-ready after reset
)(
	input  wire logic       core_clk,      // 40 MHz clock
	input  wire logic       rst,           // Synchronous reset, active high
	input  wire logic       filt_set,      // Requested filter state
	input  wire logic [7:0] lsb_set,       // Requested raw low byte
	output logic            por_not_ready, // Not-ready flag
	output logic            filter_enabled,// Filter state
	output logic [7:0]      remote_lsb_raw // Raw signed low byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int ready_cnt;                         // Cycles since reset, held at READY_DELAY

	// ****************************************
	// Power-on ready: not ready for a while after reset, then ready
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ready_cnt <= 0;
			por_not_ready <= 1'h1;
		end else begin
			if (ready_cnt < READY_DELAY) begin
				ready_cnt <= ready_cnt + 1;
			end
			por_not_ready <= (ready_cnt < READY_DELAY);
		end
	end

	// Measurement side settles one cycle after a request
	always_ff @(posedge core_clk) begin
		filter_enabled <= filt_set;
		remote_lsb_raw <= lsb_set;
	end
endmodule : sensor_status_model

// *** dv/tb.sv ***
// Self-checking bench for the fan-control configuration bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fan_pkg::*;
	logic       core_clk, rst, reg_wr, reg_rd, filt_set;  // Drives
	logic [7:0] reg_addr, reg_wdata, lsb_set, rd_val;     // Bus values
	reg8_t      reg_rdata, diode_mode, pwm_rpm_config, spinup_config;
	reg8_t      pwm_freq, pwm_value, lut_offset, lut_hyst, enhanced_fan_configuration;
	logic       fan_program_enable, enhanced_active, smoothing_enable;
	logic       high_res_enable, lut_half_degree, por_not_ready, filter_enabled;
	logic [7:0] signed_lsb_out, remote_lsb_raw;           // Low byte paths
	int         num_errors, cmp_count, polls;             // Counters
	logic [7:0] ra [10] = '{8'h30, 8'h4a, 8'h4b, 8'h4d, 8'h4f, 8'h45, 8'h04, 8'h0b, 8'h0d, 8'h4c};
	logic [7:0] rv [10] = '{8'h02, 8'h20, 8'h3f, 8'h17, 8'h04, 8'h00, 8'h08, 8'h46, 8'h55, 8'h00};

	fan_control_config_regs dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.por_not_ready(por_not_ready), .filter_enabled(filter_enabled),
		.remote_lsb_raw(remote_lsb_raw), .diode_mode(diode_mode), .pwm_rpm_config(pwm_rpm_config),
		.spinup_config(spinup_config), .pwm_freq(pwm_freq), .pwm_value(pwm_value),
		.lut_offset(lut_offset), .lut_hyst(lut_hyst),
		.enhanced_fan_configuration(enhanced_fan_configuration),
		.fan_program_enable(fan_program_enable), .enhanced_active(enhanced_active),
		.smoothing_enable(smoothing_enable), .high_res_enable(high_res_enable),
		.lut_half_degree(lut_half_degree), .signed_lsb_out(signed_lsb_out));

	sensor_status_model far (.core_clk(core_clk), .rst(rst), .filt_set(filt_set), .lsb_set(lsb_set),
		.por_not_ready(por_not_ready), .filter_enabled(filter_enabled), .remote_lsb_raw(remote_lsb_raw));

	// Clock at 25 ns period
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// One-cycle write strobe at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge core_clk);
		reg_wr = 1'h0;
	endtask : wr

	// One-cycle read strobe; data is valid one edge later
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge core_clk);
		reg_rd = 1'h0;
		rd_val = reg_rdata;
	endtask : rd

	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		cmp(rd_val, e);
	endtask : chk

	// Poll power-on status until the not-ready flag clears
	task automatic wait_ready;
		polls = 0;
		rd(8'h33);
		while (rd_val[7] !== 1'h0 && polls < 100) begin
			rd(8'h33);
			polls++;
		end
	endtask : wait_ready

	task automatic end_sim;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	// Watchdog well past the expected run length
	initial begin
		#500000;
		num_errors++;
		end_sim();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, reg_wr, reg_rd, filt_set} = 4'h8;
		{reg_addr, reg_wdata, lsb_set} = 24'h0;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'h0;
		rd(8'h33);
		cmp(8'(rd_val[7]), 8'h01);
		wait_ready();
		cmp(8'(rd_val[7]), 8'h00);
		for (int i = 0; i < 10; i++) chk(ra[i], rv[i]);
		wr(8'h30, 8'hff);
		chk(8'h30, 8'h02);
		wr(8'h4a, 8'hff);
		chk(8'h4a, 8'h3f);
		wr(8'h4a, 8'h3b);
		chk(8'h4a, 8'h3b);
		wr(8'h4b, 8'h12);
		chk(8'h4b, 8'h12);
		cmp(spinup_config, 8'h12);
		wr(8'h4d, 8'h08);
		cmp(8'(enhanced_active), 8'h01);
		wr(8'h45, 8'hff);
		chk(8'h45, 8'h7f);
		cmp({smoothing_enable, high_res_enable, lut_half_degree}, 8'h07);
		lsb_set = 8'hff;
		filt_set = 1'h1;
		chk(8'h10, 8'hff);
		filt_set = 1'h0;
		chk(8'h10, 8'he7);
		wr(8'h4d, 8'h17);
		cmp({enhanced_active, smoothing_enable, high_res_enable}, 8'h00);
		wr(8'h45, 8'h07);
		filt_set = 1'h1;
		chk(8'h10, 8'he7);
		cmp(8'(lut_half_degree), 8'h00);
		wr(8'h4e, 8'h33);
		chk(8'h4e, 8'h33);
		wr(8'h67, 8'h3c);
		chk(8'h67, 8'h3c);
		wr(8'h0d, 8'h5a);
		chk(8'h07, 8'h5a);
		wr(8'h03, 8'h11);
		chk(8'h09, 8'h11);
		wr(8'h09, 8'h22);
		chk(8'h03, 8'h22);
		wr(8'h4a, 8'h1b);
		cmp(8'(fan_program_enable), 8'h00);
		wr(8'h4b, 8'h00);
		chk(8'h4b, 8'h12);
		wr(8'h4e, 8'h00);
		chk(8'h4e, 8'h33);
		wr(8'h50, 8'h11);
		chk(8'h50, 8'h00);
		wr(8'h45, 8'h40);
		chk(8'h45, 8'h47);
		wr(8'h0b, 8'h21);
		chk(8'h05, 8'h21);
		chk(8'h40, 8'h00);
		// Mid-run reset, then a second setup that takes the direct duty option
		@(negedge core_clk);
		rst = 1'h1;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'h0;
		cmp(8'(fan_program_enable), 8'h01);
		wait_ready();
		cmp(8'(rd_val[7]), 8'h00);
		wr(8'h30, 8'h00);
		chk(8'h30, 8'h00);
		wr(8'h4a, 8'h3b);
		wr(8'h4b, 8'h12);
		wr(8'h4d, 8'h08);
		wr(8'h45, 8'h10);
		cmp(8'(high_res_enable), 8'h01);
		wr(8'h4c, 8'hff);
		chk(8'h4c, 8'hff);
		end_sim();
	end
endmodule : tb

// *** hdl/fan_consts.svh ***
// Register offsets, bit positions and reset values for the fan-control configuration bank
// Operation
// [R1] Host waits for not-ready bit clear
// [R2] Host sets diode beta mode second
// [R3] Host writes tach, clock, polarity bits
// [R4] Host writes spin-up settings next
// [R5] Host writes PWM frequency next
// [R6] Enhanced fan functions only at 22.5 kHz
// [R7] Host writes table or direct duty
// [R8] Direct duty six or eight bits
// [R9] Table option ends clearing program enable
// [R10] Setup writes accepted only when enabled
// [R11] Other registers writable at any time
// [R12] Mirror addresses reach the same register
// [R13] Enhanced configuration bit 7 reads zero
// [R14] Signed low bits masked unless enabled
// [R15] Table temperature step set by bit 5
`ifndef FAN_CONSTS_SVH
`define FAN_CONSTS_SVH

// ****************************************
// Primary offsets
// ****************************************
`define OFS_CONFIG       8'h03
`define OFS_CONV_RATE    8'h04
`define OFS_LOCAL_HIGH   8'h05
`define OFS_REMOTE_HIGH  8'h07
`define OFS_REMOTE_LOW   8'h08
`define OFS_REMOTE_LSB   8'h10
`define OFS_DIODE_MODE   8'h30
`define OFS_POR_STATUS   8'h33
`define OFS_ENH_CFG      8'h45
`define OFS_PWM_RPM_CFG  8'h4a
`define OFS_SPINUP_CFG   8'h4b
`define OFS_PWM_VALUE    8'h4c
`define OFS_PWM_FREQ     8'h4d
`define OFS_LUT_OFFSET   8'h4e
`define OFS_LUT_HYST     8'h4f
`define OFS_LUT_FIRST    8'h50
`define OFS_LUT_LAST     8'h67

// ****************************************
// Mirror offsets
// ****************************************
`define MIR_CONFIG       8'h09
`define MIR_CONV_RATE    8'h0a
`define MIR_LOCAL_HIGH   8'h0b
`define MIR_REMOTE_HIGH  8'h0d
`define MIR_REMOTE_LOW   8'h0e

// ****************************************
// Reset values
// ****************************************
`define RST_ZERO         8'h00
`define RST_CONV_RATE    8'h08
`define RST_LOCAL_HIGH   8'h46
`define RST_REMOTE_HIGH  8'h55
`define RST_DIODE_MODE   8'h02
`define RST_PWM_RPM_CFG  8'h20
`define RST_SPINUP_CFG   8'h3f
`define RST_PWM_FREQ     8'h17
`define RST_LUT_HYST     8'h04

// ****************************************
// Field positions and codes
// ****************************************
`define BIT_PROG_EN      5
`define MASK_PWM_RPM     8'h3f
`define MASK_SPINUP      8'h3f
`define MASK_FREQ        8'h1f
`define MASK_DIODE       8'h02
`define MASK_ENH_FREE    8'h78
`define MASK_ENH_GATED   8'h07
`define BIT_ENH_SIGNED   6
`define BIT_ENH_LUT_RES  5
`define BIT_ENH_HIRES    4
`define BIT_ENH_SMOOTH   0
`define BIT_CLK_SEL      3
`define FREQ_HIRES_CODE  5'h08
`define MASK_LSB_FINE    8'he7
`define BIT_NOT_READY    7

`endif

// *** hdl/fan_control_config_regs.sv ***
// Fan-control configuration register bank with program-enable gate and mirrors
`include "fan_consts.svh"

module fan_control_config_regs
	import fan_pkg::*;
#(
	parameter int LUT_BYTES = 24                // Lookup table bytes
)(
	input  wire logic       core_clk,         // 40 MHz clock
	input  wire logic       rst,              // Synchronous reset, active high
	input  wire logic [7:0] reg_addr,         // Register address
	input  wire logic       reg_wr,           // Write strobe
	input  wire logic [7:0] reg_wdata,        // Write data
	input  wire logic       reg_rd,           // Read strobe
	output reg8_t           reg_rdata,        // Read data, one cycle after strobe
	input  wire logic       por_not_ready,    // Power-on not-ready status
	input  wire logic       filter_enabled,   // Digital filter is on
	input  wire logic [7:0] remote_lsb_raw,   // Raw signed remote low byte
	output reg8_t           diode_mode,       // Diode beta mode register
	output reg8_t           pwm_rpm_config,   // PWM and tach configuration
	output reg8_t           spinup_config,    // Spin-up configuration
	output reg8_t           pwm_freq,         // PWM frequency
	output reg8_t           pwm_value,        // Direct duty value
	output reg8_t           lut_offset,       // Table temperature offset
	output reg8_t           lut_hyst,         // Table hysteresis
	output reg8_t           enhanced_fan_configuration, // Enhanced configuration
	output logic            fan_program_enable, // Setup writes allowed
	output logic            enhanced_active,  // 22.5 kHz selected
	output logic            smoothing_enable, // Table smoothing active
	output logic            high_res_enable,  // Extended duty resolution active
	output logic            lut_half_degree,  // Table step 0.5 degree
	output logic [7:0]      signed_lsb_out    // Remote low byte as presented
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0]  canon_addr;                  // Folded address
	wr_class_t   wr_class;                    // Access class
	logic        wr_free;                     // Free write accepted
	logic        wr_gated;                    // Gated write accepted
	reg8_t       config_reg;                  // General configuration
	reg8_t       conv_rate_reg;               // Conversion rate
	reg8_t       local_high_reg;              // Local high setpoint
	reg8_t       remote_high_reg;             // Remote high setpoint
	reg8_t       remote_low_reg;              // Remote low setpoint
	reg8_t       lut_mem [LUT_BYTES];         // Lookup table storage
	reg8_t       rdata_next;                  // Read mux
	logic [4:0]  lut_idx;                     // Table index

	// ****************************************
	// Decode
	// ****************************************
	mirror_decode u_decode (
		.raw_addr   (reg_addr),
		.canon_addr (canon_addr),
		.wr_class   (wr_class)
	);

	assign fan_program_enable = pwm_rpm_config[`BIT_PROG_EN];
	assign wr_free  = reg_wr && wr_class == WR_FREE;                        // [R11]
	assign wr_gated = reg_wr && wr_class == WR_GATED && fan_program_enable; // [R10]
	assign lut_idx  = 5'(canon_addr - `OFS_LUT_FIRST);

	// ****************************************
	// Free registers
	// ****************************************
	// Legacy registers reached by primary or mirror address
	always_ff @(posedge core_clk) begin
		if (rst) begin
			config_reg      <= `RST_ZERO;
			conv_rate_reg   <= `RST_CONV_RATE;
			local_high_reg  <= `RST_LOCAL_HIGH;
			remote_high_reg <= `RST_REMOTE_HIGH;
			remote_low_reg  <= `RST_ZERO;
		end else if (wr_free) begin
			case (canon_addr)
				`OFS_CONFIG:      config_reg      <= reg_wdata; // [R12]
				`OFS_CONV_RATE:   conv_rate_reg   <= reg_wdata; // [R12]
				`OFS_LOCAL_HIGH:  local_high_reg  <= reg_wdata; // [R12]
				`OFS_REMOTE_HIGH: remote_high_reg <= reg_wdata; // [R12]
				`OFS_REMOTE_LOW:  remote_low_reg  <= reg_wdata; // [R12]
				default: ;
			endcase
		end
	end

	// Diode mode and PWM/tach configuration, always writable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			diode_mode     <= `RST_DIODE_MODE;
			pwm_rpm_config <= `RST_PWM_RPM_CFG;
		end else if (wr_free) begin
			if (canon_addr == `OFS_DIODE_MODE) begin
				diode_mode <= reg_wdata & `MASK_DIODE;
			end
			if (canon_addr == `OFS_PWM_RPM_CFG) begin
				pwm_rpm_config <= reg_wdata & `MASK_PWM_RPM; // [R11]
			end
		end
	end

	// ****************************************
	// Enhanced configuration
	// ****************************************
	// Upper bits free, smoothing bits need program enable, bit 7 stays 0
	always_ff @(posedge core_clk) begin
		if (rst) begin
			enhanced_fan_configuration <= `RST_ZERO;
		end else if (reg_wr && canon_addr == `OFS_ENH_CFG) begin
			enhanced_fan_configuration <= (reg_wdata & `MASK_ENH_FREE) |           // [R13]
				(fan_program_enable ? (reg_wdata & `MASK_ENH_GATED)                   // [R10]
				                    : (enhanced_fan_configuration & `MASK_ENH_GATED));
		end
	end

	// ****************************************
	// Gated setup registers
	// ****************************************
	// Spin-up, frequency, duty, offset and hysteresis
	always_ff @(posedge core_clk) begin
		if (rst) begin
			spinup_config <= `RST_SPINUP_CFG;
			pwm_freq      <= `RST_PWM_FREQ;
			pwm_value     <= `RST_ZERO;
			lut_offset    <= `RST_ZERO;
			lut_hyst      <= `RST_LUT_HYST;
		end else if (wr_gated) begin
			case (canon_addr)
				`OFS_SPINUP_CFG: spinup_config <= reg_wdata & `MASK_SPINUP; // [R10]
				`OFS_PWM_FREQ:   pwm_freq      <= reg_wdata & `MASK_FREQ;   // [R10]
				`OFS_PWM_VALUE:  pwm_value     <= reg_wdata;                // [R10]
				`OFS_LUT_OFFSET: lut_offset    <= reg_wdata;                // [R10]
				`OFS_LUT_HYST:   lut_hyst      <= reg_wdata;                // [R10]
				default: ;
			endcase
		end
	end

	// Lookup table entries
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < LUT_BYTES; i++) begin
				lut_mem[i] <= `RST_ZERO;
			end
		end else if (wr_gated && canon_addr >= `OFS_LUT_FIRST) begin
			lut_mem[lut_idx] <= reg_wdata; // [R10]
		end
	end

	// ****************************************
	// Derived controls
	// ****************************************
	// Smoothing and extended resolution exist only with the fast clock and 22.5 kHz code
	assign enhanced_active  = pwm_rpm_config[`BIT_CLK_SEL] && pwm_freq[4:0] == `FREQ_HIRES_CODE; // [R6]
	assign smoothing_enable = enhanced_active && enhanced_fan_configuration[`BIT_ENH_SMOOTH];    // [R6]
	assign high_res_enable  = enhanced_active && enhanced_fan_configuration[`BIT_ENH_HIRES];     // [R6]
	assign lut_half_degree  = enhanced_fan_configuration[`BIT_ENH_LUT_RES];                      // [R15]
	// Fine low bits pass only when enabled and filter running
	assign signed_lsb_out = (enhanced_fan_configuration[`BIT_ENH_SIGNED] && filter_enabled) ?
	                        remote_lsb_raw : (remote_lsb_raw & `MASK_LSB_FINE);                 // [R14]

	// ****************************************
	// Read path
	// ****************************************
	// Read mux, unmapped addresses read zero
	always_comb begin
		rdata_next = `RST_ZERO;
		if (canon_addr >= `OFS_LUT_FIRST && canon_addr <= `OFS_LUT_LAST) begin
			rdata_next = lut_mem[lut_idx];
		end else begin
			case (canon_addr)
				`OFS_CONFIG:      rdata_next = config_reg;       // [R12]
				`OFS_CONV_RATE:   rdata_next = conv_rate_reg;    // [R12]
				`OFS_LOCAL_HIGH:  rdata_next = local_high_reg;   // [R12]
				`OFS_REMOTE_HIGH: rdata_next = remote_high_reg;  // [R12]
				`OFS_REMOTE_LOW:  rdata_next = remote_low_reg;   // [R12]
				`OFS_REMOTE_LSB:  rdata_next = signed_lsb_out;   // [R14]
				`OFS_DIODE_MODE:  rdata_next = diode_mode;
				`OFS_POR_STATUS:  rdata_next = {por_not_ready, 7'h00};
				`OFS_ENH_CFG:     rdata_next = enhanced_fan_configuration; // [R13]
				`OFS_PWM_RPM_CFG: rdata_next = pwm_rpm_config;
				`OFS_SPINUP_CFG:  rdata_next = spinup_config;
				`OFS_PWM_VALUE:   rdata_next = pwm_value;
				`OFS_PWM_FREQ:    rdata_next = pwm_freq;
				`OFS_LUT_OFFSET:  rdata_next = lut_offset;
				`OFS_LUT_HYST:    rdata_next = lut_hyst;
				default:          rdata_next = `RST_ZERO;
			endcase
		end
	end

	// Read data register, updated on a read strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= `RST_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	enh_bit7_a: assert property (enhanced_fan_configuration[7] == 1'b0) // [R13]
		else $error("enhanced configuration bit 7 set");
	gate_block_a: assert property ((reg_wr && reg_addr == `OFS_SPINUP_CFG && !fan_program_enable) // [R10]
		|=> $stable(spinup_config))
		else $error("spin-up written while programming disabled");
	gate_pass_a: assert property ((reg_wr && reg_addr == `OFS_PWM_VALUE && fan_program_enable) // [R10]
		|=> pwm_value == $past(reg_wdata))
		else $error("duty write lost while programming enabled");
	free_write_a: assert property ((reg_wr && reg_addr == `OFS_PWM_RPM_CFG) // [R11]
		|=> pwm_rpm_config == ($past(reg_wdata) & `MASK_PWM_RPM))
		else $error("free configuration write not taken");
	mirror_read_a: assert property ((reg_rd && reg_addr == `MIR_REMOTE_HIGH) // [R12]
		|=> reg_rdata == $past(remote_high_reg))
		else $error("mirror read differs from primary");
	mirror_write_a: assert property ((reg_wr && reg_addr == `MIR_CONFIG) // [R12]
		|=> config_reg == $past(reg_wdata))
		else $error("mirror write not seen at primary");
	smooth_freq_a: assert property (smoothing_enable |-> pwm_freq[4:0] == `FREQ_HIRES_CODE) // [R6]
		else $error("smoothing active away from 22.5 kHz");
	lsb_mask_a: assert property (!enhanced_fan_configuration[`BIT_ENH_SIGNED] |-> signed_lsb_out[4:3] == 2'b00) // [R14]
		else $error("fine low bits shown while disabled");
	lut_res_a: assert property ((reg_wr && canon_addr == `OFS_ENH_CFG) // [R15]
		|=> lut_half_degree == $past(reg_wdata[`BIT_ENH_LUT_RES]))
		else $error("table step does not follow resolution bit");

	prog_close_c: cover property (fan_program_enable ##1 !fan_program_enable);
	enh_on_c:     cover property (enhanced_active && smoothing_enable);
	lut_write_c:  cover property (wr_gated && canon_addr == `OFS_LUT_LAST);
	blocked_c:    cover property (reg_wr && wr_class == WR_GATED && !fan_program_enable);

endmodule : fan_control_config_regs

// *** hdl/fan_pkg.sv ***
// Shared types for the fan-control configuration bank
package fan_pkg;

	typedef logic [7:0] reg8_t;            // One 8-bit register

	typedef enum logic [1:0] {
		WR_FREE,                             // Always writable
		WR_GATED,                            // Writable only with program enable
		WR_NONE                              // Read only or unmapped
	} wr_class_t;

endpackage : fan_pkg

// *** hdl/mirror_decode.sv ***
// Folds mirror addresses onto primary ones and classifies write access
`include "fan_consts.svh"

module mirror_decode
	import fan_pkg::*;
(
	input  wire logic [7:0] raw_addr,   // Address from the register port
	output logic      [7:0] canon_addr, // Primary address
	output wr_class_t       wr_class    // Write access class
);

	// ****************************************
	// Mirror folding
	// ****************************************
	// Mirror and primary land on one register
	always_comb begin
		case (raw_addr)
			`MIR_CONFIG:      canon_addr = `OFS_CONFIG;      // [R12]
			`MIR_CONV_RATE:   canon_addr = `OFS_CONV_RATE;   // [R12]
			`MIR_LOCAL_HIGH:  canon_addr = `OFS_LOCAL_HIGH;  // [R12]
			`MIR_REMOTE_HIGH: canon_addr = `OFS_REMOTE_HIGH; // [R12]
			`MIR_REMOTE_LOW:  canon_addr = `OFS_REMOTE_LOW;  // [R12]
			default:          canon_addr = raw_addr;
		endcase
	end

	// ****************************************
	// Access class
	// ****************************************
	// Fan setup registers need program enable, the listed ones are free, all others are not writable
	always_comb begin
		if (canon_addr >= `OFS_SPINUP_CFG && canon_addr <= `OFS_LUT_LAST) begin
			wr_class = WR_GATED;                                 // [R10]
		end else begin
			case (canon_addr)
				`OFS_CONFIG, `OFS_CONV_RATE, `OFS_LOCAL_HIGH,
				`OFS_REMOTE_HIGH, `OFS_REMOTE_LOW, `OFS_DIODE_MODE,
				`OFS_ENH_CFG, `OFS_PWM_RPM_CFG: wr_class = WR_FREE; // [R11]
				default:                       wr_class = WR_NONE;
			endcase
		end
	end

endmodule : mirror_decode
